// [pds_pkg.sv]
// presence-detect store: shared constants, content bytes and state types
// assumes: a 50 MHz system clock; the two-wire link clock comes from the host
package pds_pkg;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_MHZ      = 50;
    localparam int PROG_TIME_MS = 10;
    localparam int PROG_CYCLES  = PROG_TIME_MS * 1000 * CLK_MHZ;
    localparam int PROG_CNT_W   = 20;
    localparam int PAGE_BYTES   = 16;

    // ------------------------------------------------------------------
    // content byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_BYTES_USED  = 8'h00;
    localparam logic [7:0] OFS_STORE_SIZE  = 8'h01;
    localparam logic [7:0] OFS_MEM_TYPE    = 8'h02;
    localparam logic [7:0] OFS_ROW_BITS    = 8'h03;
    localparam logic [7:0] OFS_COL_BITS    = 8'h04;
    localparam logic [7:0] OFS_RANKS       = 8'h05;
    localparam logic [7:0] OFS_WIDTH_LO    = 8'h06;
    localparam logic [7:0] OFS_WIDTH_HI    = 8'h07;
    localparam logic [7:0] OFS_IF_LEVELS   = 8'h08;
    localparam logic [7:0] OFS_CYCLE_CL3   = 8'h09;
    localparam logic [7:0] OFS_ACCESS_CL3  = 8'h0a;
    localparam logic [7:0] OFS_CONFIG      = 8'h0b;
    localparam logic [7:0] OFS_REFRESH     = 8'h0c;
    localparam logic [7:0] OFS_PRIM_WIDTH  = 8'h0d;
    localparam logic [7:0] OFS_CHECK_WIDTH = 8'h0e;
    localparam logic [7:0] OFS_COL_TO_COL  = 8'h0f;

    // ------------------------------------------------------------------
    // content byte values after reset
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_BYTES_USED  = 8'h80;
    localparam logic [7:0] RST_STORE_SIZE  = 8'h08;
    localparam logic [7:0] RST_MEM_TYPE    = 8'h04;
    localparam logic [7:0] RST_ROW_BITS    = 8'h0d;
    localparam logic [7:0] RST_COL_BITS    = 8'h0a;
    localparam logic [7:0] RST_RANKS       = 8'h01;
    localparam logic [7:0] RST_WIDTH_LO    = 8'h40;
    localparam logic [7:0] RST_WIDTH_HI    = 8'h00;
    localparam logic [7:0] RST_IF_LEVELS   = 8'h01;
    localparam logic [7:0] RST_CYCLE_CL3   = 8'h75;
    localparam logic [7:0] RST_ACCESS_CL3  = 8'h54;
    localparam logic [7:0] RST_CONFIG      = 8'h00;
    localparam logic [7:0] RST_REFRESH     = 8'h82;
    localparam logic [7:0] RST_PRIM_WIDTH  = 8'h08;
    localparam logic [7:0] RST_CHECK_WIDTH = 8'h00;
    localparam logic [7:0] RST_COL_TO_COL  = 8'h01;
    localparam logic [7:0] RST_UNUSED      = 8'hff;

    // ------------------------------------------------------------------
    // states
    // ------------------------------------------------------------------
    typedef enum logic [4:0] {
        LK_SEL    = 5'b00001,
        LK_ADDR   = 5'b00010,
        LK_WDATA  = 5'b00100,
        LK_RDATA  = 5'b01000,
        LK_IGNORE = 5'b10000
    } pds_link_st_t;

    typedef enum logic [2:0] {
        CT_IDLE   = 3'b001,
        CT_ACTIVE = 3'b010,
        CT_PROG   = 3'b100
    } pds_ctrl_st_t;

endpackage

// [pds_eeprom_slave.sv]
// presence-detect store: two-wire serial eeprom slave serving module parameter bytes
// assumes: scl_i is the host's serial clock, idle high; sda is open drain with a pull-up
`timescale 1ns/100ps

// What this block does
// - select and data bytes travel most significant bit first.
// - array select byte is type id, three strap bits, direction bit.
// - a second type id selects the protection register, same lower bits.
// - select with direction 1 returns the byte at the current address.
// - write select plus address, then restart and read select, returns that byte.
// - reads continue with consecutive bytes while the master acknowledges.
// - byte and page writes of up to 16 bytes only while write control is low.
// - stop after an accepted array write launches programming, finished within 10 ms.
// - while programming the link is ignored, data line released, no acknowledge.
// - byte 0 reads 0x80 and byte 1 reads 0x08.
// - byte 3 reads 0x0d and byte 4 reads 0x0a.
// - byte 5 gives the rank count, 0x01 or 0x02.
// - bytes 6 and 7 read 0x40 and 0x00; byte 8 reads 0x01.
// - byte 9 is cycle time 0x70, 0x75 or 0x80; byte 10 is 0x54 or 0x60.
// - byte 13 reads 0x08 and byte 14 reads 0x00.
// - byte 15 reads 0x01.
// - start and stop are data edges with clock high; stop returns to standby.
// - acknowledge in the ninth clock after own select byte and written bytes.
// - during reads a missing master acknowledge ends transmission until stop or repeated start.
module pds_eeprom_slave #(
    parameter int         PROG_CYCLES_P = pds_pkg::PROG_CYCLES, // programming time in cycles
    parameter int         CNT_W         = pds_pkg::PROG_CNT_W,  // programming counter width
    parameter logic [3:0] MEM_TYPE_ID   = 4'h5,  // arbitrary value
    parameter logic [3:0] PROT_TYPE_ID  = 4'h3,  // arbitrary value
    parameter logic [7:0] RANK_BYTE     = pds_pkg::RST_RANKS,      // single or dual rank
    parameter logic [7:0] CYCLE_BYTE    = pds_pkg::RST_CYCLE_CL3,  // fitted speed grade
    parameter logic [7:0] ACCESS_BYTE   = pds_pkg::RST_ACCESS_CL3  // fitted speed grade
) (
    input  wire logic clock_i,             // system clock, 50 MHz
    input  wire logic rst_b_i,             // asynchronous reset, active low
    input  wire logic scl_i,               // serial link clock from the host
    input  wire logic sda_i,               // serial data line level
    output logic      sda_o,               // serial data drive value, always low
    output logic      sda_oe_o,            // pulls the data line low when high
    input  wire logic strap_addr_bit2_i,   // module address strap, bit 2
    input  wire logic strap_addr_bit1_i,   // module address strap, bit 1
    input  wire logic strap_addr_bit0_i,   // module address strap, bit 0
    input  wire logic write_control_pin_i  // low permits writes
);
    import pds_pkg::*;

    localparam int DEPTH = 256;

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    pds_link_st_t st_q;
    pds_ctrl_st_t ctrl_q;
    pds_ctrl_st_t ctrl_d;
    logic [3:0]   bit_cnt_q;
    logic [7:0]   shift_q;
    logic         ack_q;
    logic         rd_q;
    logic         prot_sel_q;
    logic [15:0]  wr_mask_q;
    logic [7:0]   addr_q;
    logic [7:0]   buf_q [0:PAGE_BYTES-1];
    logic [7:0]   prot_q;
    logic [7:0]   tx_q;
    logic         oe_q;
    logic [2:0]   strap_m_q;
    logic [2:0]   strap_s_q;
    logic         wlock_m_q;
    logic         wlock_s_q;
    logic         scl_m_q;
    logic         scl_s_q;
    logic         scl_p_q;
    logic         sda_m_q;
    logic         sda_s_q;
    logic         sda_p_q;
    logic         hold_q;
    logic         sda_o_q;
    logic [CNT_W-1:0] prog_cnt_q;
    logic [15:0]  prog_mask_q;
    logic [3:0]   prog_page_q;
    logic [7:0]   mem_q [0:DEPTH-1];
    logic [7:0]   rd_byte_q;
    logic         link_rst_n;
    logic [7:0]   byte_w;
    logic         sel_mem_w;
    logic         sel_prot_w;
    logic [7:0]   tx_src_w;
    logic         start_w;
    logic         stop_w;
    logic         prog_done_w;

    // the link logic is held in reset outside frames and while programming;
    // the hold is released while scl is high, so no link edge meets it
    assign link_rst_n = rst_b_i & ~hold_q;
    assign byte_w     = {shift_q[6:0], sda_i};
    assign sel_mem_w  = (byte_w[7:4] == MEM_TYPE_ID) && (byte_w[3:1] == strap_s_q);
    assign sel_prot_w = (byte_w[7:4] == PROT_TYPE_ID) && (byte_w[3:1] == strap_s_q);
    assign tx_src_w   = prot_sel_q ? prot_q : rd_byte_q;
    assign sda_o      = sda_o_q;
    assign sda_oe_o   = oe_q;

    // ------------------------------------------------------------------
    // link domain: strap and write control synchronisers
    // ------------------------------------------------------------------
    always_ff @(posedge scl_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            strap_m_q <= 3'h0;
            strap_s_q <= 3'h0;
            wlock_m_q <= 1'b1;
            wlock_s_q <= 1'b1;
        end else begin
            strap_m_q <= {strap_addr_bit2_i, strap_addr_bit1_i, strap_addr_bit0_i};
            strap_s_q <= strap_m_q;
            wlock_m_q <= write_control_pin_i;
            wlock_s_q <= wlock_m_q;
        end
    end

    // ------------------------------------------------------------------
    // link domain: bit engine, sampled on the rising clock
    // ------------------------------------------------------------------
    always_ff @(posedge scl_i or negedge link_rst_n) begin
        if (!link_rst_n) begin
            st_q       <= LK_SEL;
            bit_cnt_q  <= 4'h0;
            shift_q    <= 8'h00;
            ack_q      <= 1'b0;
            rd_q       <= 1'b0;
            prot_sel_q <= 1'b0;
            wr_mask_q  <= 16'h0000;
        end else begin
            bit_cnt_q <= (bit_cnt_q == 4'h8) ? 4'h0 : bit_cnt_q + 4'h1;
            if (bit_cnt_q < 4'h8) begin
                shift_q <= byte_w;
            end
            if (bit_cnt_q == 4'h7) begin
                case (st_q)
                    LK_SEL: begin
                        ack_q      <= sel_mem_w | sel_prot_w;
                        rd_q       <= byte_w[0];
                        prot_sel_q <= sel_prot_w;
                    end
                    LK_ADDR:  ack_q <= 1'b1;
                    LK_WDATA: begin
                        ack_q <= ~wlock_s_q;
                        if (!wlock_s_q && !prot_sel_q) begin
                            wr_mask_q[addr_q[3:0]] <= 1'b1;
                        end
                    end
                    default:  ack_q <= 1'b0;
                endcase
            end
            if (bit_cnt_q == 4'h8) begin
                case (st_q)
                    LK_SEL: begin
                        if (!ack_q) begin
                            st_q <= LK_IGNORE;
                        end else if (rd_q) begin
                            st_q <= LK_RDATA;
                        end else begin
                            st_q <= prot_sel_q ? LK_WDATA : LK_ADDR;
                        end
                    end
                    LK_ADDR:  st_q <= LK_WDATA;
                    LK_RDATA: begin
                        if (sda_i) begin
                            st_q <= LK_IGNORE;
                        end
                    end
                    default:  st_q <= st_q;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // link domain: address pointer, page buffer, protection byte
    // ------------------------------------------------------------------
    // these survive frames so a current-address read follows the last access
    always_ff @(posedge scl_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            addr_q <= 8'h00;
            prot_q <= 8'h00;
            for (int i = 0; i < PAGE_BYTES; i++) begin
                buf_q[i] <= 8'h00;
            end
        end else if (bit_cnt_q == 4'h7 && st_q == LK_ADDR) begin
            addr_q <= byte_w;
        end else if (bit_cnt_q == 4'h7 && st_q == LK_WDATA && !wlock_s_q) begin
            if (prot_sel_q) begin
                prot_q <= byte_w;
            end else begin
                buf_q[addr_q[3:0]] <= byte_w;
                addr_q[3:0]        <= addr_q[3:0] + 4'h1;
            end
        end else if (bit_cnt_q == 4'h8 && st_q == LK_RDATA && !prot_sel_q) begin
            addr_q <= addr_q + 8'h01;
        end
    end

    // ------------------------------------------------------------------
    // link domain: data line drive, changed on the falling clock
    // ------------------------------------------------------------------
    always_ff @(negedge scl_i or negedge link_rst_n) begin
        if (!link_rst_n) begin
            oe_q <= 1'b0;
            tx_q <= 8'h00;
        end else begin
            case (bit_cnt_q)
                4'h8: oe_q <= ack_q && (st_q != LK_RDATA);
                4'h0: begin
                    oe_q <= (st_q == LK_RDATA) && !tx_src_w[7];
                    tx_q <= {tx_src_w[6:0], 1'b0};
                end
                default: begin
                    oe_q <= (st_q == LK_RDATA) && !tx_q[7];
                    tx_q <= {tx_q[6:0], 1'b0};
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // system domain: pin synchronisers and start/stop detection
    // ------------------------------------------------------------------
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            scl_m_q <= 1'b1;
            scl_s_q <= 1'b1;
            scl_p_q <= 1'b1;
            sda_m_q <= 1'b1;
            sda_s_q <= 1'b1;
            sda_p_q <= 1'b1;
            sda_o_q <= 1'b0;
        end else begin
            scl_m_q <= scl_i;
            scl_s_q <= scl_m_q;
            scl_p_q <= scl_s_q;
            sda_m_q <= sda_i;
            sda_s_q <= sda_m_q;
            sda_p_q <= sda_s_q;
            sda_o_q <= 1'b0;
        end
    end

    assign start_w = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
    assign stop_w  = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;
    assign prog_done_w = (ctrl_q == CT_PROG) && (prog_cnt_q == CNT_W'(PROG_CYCLES_P - 1));

    // ------------------------------------------------------------------
    // system domain: frame and programming control
    // ------------------------------------------------------------------
    always_comb begin
        ctrl_d = ctrl_q;
        case (ctrl_q)
            CT_IDLE:   if (start_w) ctrl_d = CT_ACTIVE;
            CT_ACTIVE: if (stop_w) ctrl_d = (wr_mask_q != 16'h0000) ? CT_PROG : CT_IDLE;
            CT_PROG:   if (prog_done_w) ctrl_d = CT_IDLE;
            default:   ctrl_d = CT_IDLE;
        endcase
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ctrl_q <= CT_IDLE;
            hold_q <= 1'b1;
        end else begin
            ctrl_q <= ctrl_d;
            hold_q <= (ctrl_d != CT_ACTIVE) || start_w;
        end
    end

    // the link is frozen at stop, so its mask and page are steady when copied
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            prog_cnt_q  <= '0;
            prog_mask_q <= 16'h0000;
            prog_page_q <= 4'h0;
        end else begin
            prog_cnt_q <= (ctrl_q == CT_PROG) ? prog_cnt_q + 1'b1 : '0;
            if (ctrl_q == CT_ACTIVE && ctrl_d == CT_PROG) begin
                prog_mask_q <= wr_mask_q;
                prog_page_q <= addr_q[7:4];
            end
        end
    end

    // ------------------------------------------------------------------
    // system domain: content store
    // ------------------------------------------------------------------
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= RST_UNUSED;
            end
            mem_q[OFS_BYTES_USED]  <= RST_BYTES_USED;
            mem_q[OFS_STORE_SIZE]  <= RST_STORE_SIZE;
            mem_q[OFS_MEM_TYPE]    <= RST_MEM_TYPE;
            mem_q[OFS_ROW_BITS]    <= RST_ROW_BITS;
            mem_q[OFS_COL_BITS]    <= RST_COL_BITS;
            mem_q[OFS_RANKS]       <= RANK_BYTE;
            mem_q[OFS_WIDTH_LO]    <= RST_WIDTH_LO;
            mem_q[OFS_WIDTH_HI]    <= RST_WIDTH_HI;
            mem_q[OFS_IF_LEVELS]   <= RST_IF_LEVELS;
            mem_q[OFS_CYCLE_CL3]   <= CYCLE_BYTE;
            mem_q[OFS_ACCESS_CL3]  <= ACCESS_BYTE;
            mem_q[OFS_CONFIG]      <= RST_CONFIG;
            mem_q[OFS_REFRESH]     <= RST_REFRESH;
            mem_q[OFS_PRIM_WIDTH]  <= RST_PRIM_WIDTH;
            mem_q[OFS_CHECK_WIDTH] <= RST_CHECK_WIDTH;
            mem_q[OFS_COL_TO_COL]  <= RST_COL_TO_COL;
        end else if (prog_done_w) begin
            for (int i = 0; i < PAGE_BYTES; i++) begin
                if (prog_mask_q[i]) begin
                    mem_q[{prog_page_q, 4'(i)}] <= buf_q[i];
                end
            end
        end
    end

    // the pointer only moves on a rising link edge; copying while scl is
    // high leaves a whole high phase for it to settle before the next fall
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rd_byte_q <= 8'h00;
        end else if (scl_s_q) begin
            rd_byte_q <= mem_q[addr_q];
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    a_msb_first: assert property (@(posedge scl_i) disable iff (!link_rst_n)
        (bit_cnt_q == 4'h8 && $past(bit_cnt_q, 8) == 4'h0) |-> shift_q[7] == $past(sda_i, 8))
        else $error("first received bit is not the top bit");
    a_sel_ack: assert property (@(posedge scl_i) disable iff (!link_rst_n)
        (st_q == LK_SEL && bit_cnt_q == 4'h7 && sel_mem_w) |=> sda_oe_o)
        else $error("array select byte not acknowledged");
    a_prot_ack: assert property (@(posedge scl_i) disable iff (!link_rst_n)
        (st_q == LK_SEL && bit_cnt_q == 4'h7 && sel_prot_w) |=> sda_oe_o ##1 prot_sel_q)
        else $error("protection select byte not acknowledged");
    a_write_lock: assert property (@(posedge scl_i) disable iff (!link_rst_n)
        (st_q == LK_WDATA && bit_cnt_q == 4'h7 && wlock_s_q) |=> !sda_oe_o && $stable(wr_mask_q))
        else $error("write accepted with write control high");
    a_nack_stop: assert property (@(posedge scl_i) disable iff (!link_rst_n)
        (st_q == LK_RDATA && bit_cnt_q == 4'h8 && sda_i) |=> st_q == LK_IGNORE ##1 !sda_oe_o)
        else $error("transmission went on after missing acknowledge");
    a_page_wrap: assert property (@(posedge scl_i) disable iff (!link_rst_n)
        (st_q == LK_WDATA && bit_cnt_q == 4'h7 && !wlock_s_q && !prot_sel_q)
        |=> addr_q[7:4] == $past(addr_q[7:4]) && addr_q[3:0] == $past(addr_q[3:0]) + 4'h1)
        else $error("page write pointer left its page");
    a_mismatch_quiet: assert property (@(posedge scl_i) disable iff (!link_rst_n)
        (st_q == LK_SEL && bit_cnt_q == 4'h7 && !sel_mem_w && !sel_prot_w)
        |=> !sda_oe_o ##1 st_q == LK_IGNORE)
        else $error("foreign select byte was answered");
    a_stop_launch: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        (ctrl_q == CT_ACTIVE && stop_w && wr_mask_q != 16'h0000) |=> ctrl_q == CT_PROG && hold_q)
        else $error("stop after write did not start programming");
    a_prog_bound: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        ctrl_q == CT_PROG |-> prog_cnt_q < CNT_W'(PROG_CYCLES_P))
        else $error("programming overran its time");
    a_busy_quiet: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        ctrl_q == CT_PROG |-> hold_q && !sda_oe_o)
        else $error("link active while programming");
    a_start_release: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        (ctrl_q == CT_IDLE && start_w) |=> hold_q ##1 !hold_q)
        else $error("start did not release the link logic");

endmodule

// [pds_host_model.sv]
// host model: two-wire bus master driving the link clock and pulling the data line
// assumes: the bench resolves the data line with a pull-up and feeds it back on sda_i
`timescale 1ns/100ps
module pds_host_model (
    input  wire logic clock_i,   // system clock, paces the link
    input  wire logic sda_i,     // resolved data line
    output logic      scl_o,     // link clock, high outside frames
    output logic      sda_low_o  // high pulls the data line low
);
    // ------------------------------------------------------------------
    // bus primitives
    // ------------------------------------------------------------------
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end
    // step of six clocks: bit high phases last one step, bit low phases two, the low before stop or restart one, well above the minimum
    task automatic hp();
        repeat (6) @(posedge clock_i);
    endtask
    task automatic start();
        sda_low_o <= 1'b0; hp(); scl_o <= 1'b1; hp(); sda_low_o <= 1'b1; hp(); scl_o <= 1'b0;
    endtask
    task automatic stop();
        sda_low_o <= 1'b1; hp(); scl_o <= 1'b1; hp(); sda_low_o <= 1'b0; hp();
    endtask
    task automatic bit_x(input logic b, output logic r);
        hp(); sda_low_o <= ~b; hp(); scl_o <= 1'b1; hp(); r = sda_i; scl_o <= 1'b0;
    endtask
    task automatic byte_w(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_x(d[i], r);
        bit_x(1'b1, r);
        ack = ~r;
    endtask
    task automatic byte_r(input logic ack_en, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
        bit_x(~ack_en, r);
    endtask
endmodule

// [pds_eeprom_slave_tb.sv]
// bench for the presence-detect store: register reads, page write, refusals
// assumes: the host model paces the link; design programming time set short
`timescale 1ns/100ps
module pds_eeprom_slave_tb;
    import pds_pkg::*;
    // ------------------------------------------------------------------
    // set-up
    // ------------------------------------------------------------------
    localparam logic [3:0] MEM = 4'h5;
    localparam logic [3:0] PRT = 4'h3;
    logic       clock_i = 1'b0;
    logic       rst_b_i = 1'b1;
    logic       wlock_q = 1'b1;
    logic [2:0] sa      = 3'h5;
    wire        scl;
    wire        host_low;
    wire        dev_oe;
    wire        dev_drv;
    // the line shows the device's drive value only while it is enabled
    wire        sda = ~host_low & (dev_oe ? dev_drv : 1'b1);
    int         fails = 0;
    int         n_checks = 0;
    logic       ack;
    logic [7:0] q[$];
    always #10 clock_i = ~clock_i;
    pds_eeprom_slave #(.PROG_CYCLES_P(200), .MEM_TYPE_ID(MEM), .PROT_TYPE_ID(PRT)) i_dut (
        .clock_i(clock_i), .rst_b_i(rst_b_i), .scl_i(scl), .sda_i(sda), .sda_o(dev_drv),
        .sda_oe_o(dev_oe), .strap_addr_bit2_i(sa[2]), .strap_addr_bit1_i(sa[1]),
        .strap_addr_bit0_i(sa[0]), .write_control_pin_i(wlock_q));
    pds_host_model i_host (.clock_i(clock_i), .sda_i(sda), .scl_o(scl), .sda_low_o(host_low));
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic sel(input logic [3:0] id, input logic [2:0] s, input logic r, input logic e);
        i_host.start();
        i_host.byte_w({id, s, r}, ack);
        chk("select ack", {7'h0, ack}, {7'h0, e});
    endtask
    task automatic addr(input logic [7:0] a);
        sel(MEM, sa, 1'b0, 1'b1);
        i_host.byte_w(a, ack);
        chk("addr ack", {7'h0, ack}, 8'h01);
    endtask
    // reads continue while acknowledged, the last byte is refused
    task automatic rd(input logic [3:0] id, input logic [7:0] e[$]);
        logic [7:0] d;
        sel(id, sa, 1'b1, 1'b1);
        foreach (e[i]) begin
            i_host.byte_r(i < e.size() - 1, d);
            chk("rdata", d, e[i]);
        end
        i_host.stop();
    endtask
    // ------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------
    initial begin
        #1000000;
        fails++;
        end_of_test();
    end
    initial begin
        // a real falling edge: the link-clocked flops see no clock during reset
        rst_b_i <= 1'b0;
        repeat (16) @(posedge clock_i);
        rst_b_i <= 1'b1;
        repeat (4) @(posedge clock_i);
        addr(8'h00);
        rd(MEM, '{8'h80, 8'h08, 8'h04, 8'h0d, 8'h0a, 8'h01, 8'h40, 8'h00, 8'h01, 8'h75, 8'h54,
            8'h00, 8'h82, 8'h08, 8'h00, 8'h01});
        rd(MEM, '{8'hff});
        sel(MEM, ~sa, 1'b0, 1'b0);
        i_host.stop();
        sel(4'h9, sa, 1'b0, 1'b0);
        i_host.stop();
        addr(8'h20);
        i_host.byte_w(8'haa, ack);
        chk("write lock ack", {7'h0, ack}, 8'h00);
        i_host.stop();
        addr(8'h20);
        rd(MEM, '{8'hff});
        wlock_q <= 1'b0;
        addr(8'h20);
        for (int i = 0; i < 17; i++) begin
            i_host.byte_w(8'h30 + i[7:0], ack);
            chk("page ack", {7'h0, ack}, 8'h01);
        end
        i_host.stop();
        sel(MEM, sa, 1'b0, 1'b0);
        i_host.stop();
        repeat (250) @(posedge clock_i);
        q = '{8'h40};
        for (int i = 1; i < 16; i++) q.push_back(8'h30 + i[7:0]);
        q.push_back(8'hff);
        addr(8'h20);
        rd(MEM, q);
        sel(PRT, sa, 1'b0, 1'b1);
        i_host.byte_w(8'h5a, ack);
        chk("prot ack", {7'h0, ack}, 8'h01);
        i_host.stop();
        rd(PRT, '{8'h5a});
        // a different strap setting must be followed by the select decode
        sa <= 3'h2;
        @(posedge clock_i);
        addr(OFS_STORE_SIZE);
        rd(MEM, '{RST_STORE_SIZE});
        end_of_test();
    end
endmodule
